// [mrm_pkg.sv]
// Purpose: Shared constants and types for the upper mode-register bank.
// Assumes: Byte-wide mode registers addressed by an 8-bit register address.
// Notes: Every offset, reset value, reserved mask and timing count lives here.
package mrm_pkg;

  // Register addresses.
  localparam logic [7:0] ADDR_CAL_RESET = 8'h0A;
  localparam logic [7:0] ADDR_TERMINATION = 8'h0B;
  localparam logic [7:0] ADDR_CA_VREF = 8'h0C;
  localparam logic [7:0] ADDR_REG_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_DQ_VREF = 8'h0E;
  localparam logic [7:0] ADDR_LB_INV = 8'h0F;
  localparam logic [7:0] ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] ADDR_SEG_MASK = 8'h11;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h12;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h13;
  localparam logic [7:0] ADDR_UB_INV = 8'h14;
  localparam logic [7:0] ADDR_VENDOR = 8'h15;
  localparam logic [7:0] ADDR_TERM2 = 8'h16;
  localparam logic [7:0] ADDR_OSC_RUN = 8'h17;
  localparam logic [7:0] ADDR_TRR = 8'h18;
  localparam logic [7:0] ADDR_REPAIR = 8'h19;
  localparam logic [7:0] ADDR_PAT_A = 8'h20;
  localparam logic [7:0] ADDR_PAT_B = 8'h28;

  // Reset values and reserved-bit masks of the readable registers.
  localparam logic [7:0] RST_VREF = 8'h4D;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RFU_VREF = 8'h80;
  localparam logic [7:0] RFU_NONE = 8'h00;

  // Log2 of the oscillator run-time step, in clock cycles per count of the setting.
  localparam logic [3:0] OSC_STEP_LOG2 = 4'h4;

  // Access class of an address.
  typedef enum logic [1:0] {
    MRM_ACC_NONE = 2'b00,
    MRM_ACC_RO = 2'b01,
    MRM_ACC_WO = 2'b10,
    MRM_ACC_RW = 2'b11
  } mrm_access_t;

  // Register bank state.
  typedef struct packed {
    logic [7:0] cal_reset;
    logic [7:0] termination;
    logic [7:0] ca_vref;
    logic [7:0] reg_ctrl;
    logic [7:0] dq_vref;
    logic [7:0] lb_inv;
    logic [7:0] bank_mask;
    logic [7:0] seg_mask;
    logic [7:0] ub_inv;
    logic [7:0] vendor;
    logic [7:0] term2;
    logic [7:0] osc_run;
    logic [7:0] trr;
    logic [7:0] pat_a;
    logic [7:0] pat_b;
    logic rd_valid;
    logic [7:0] rd_data;
  } mrm_state_t;

  // Strobe oscillator state.
  typedef struct packed {
    logic running;
    logic [11:0] timer;
    logic [15:0] count;
  } mrm_osc_state_t;

endpackage

// [mrm_osc_if.sv]
// Purpose: Carrier between the register bank and the strobe oscillator counter.
// Assumes: Both ends run on the same clock.
// Notes: Start and stop are one-cycle pulses.
`timescale 1ns/1ps
interface mrm_osc_if;
  logic start;
  logic stop;
  logic [7:0] run_time;
  logic [15:0] count;
  logic running;

  modport ctrl (output start, output stop, output run_time, input count, input running);
  modport osc (input start, input stop, input run_time, output count, output running);
endinterface // mrm_osc_if

// [mrm_dqs_osc.sv]
// Purpose: Strobe interval-oscillator counter with run-time stop.
// Assumes: A run-time setting of zero means run until an explicit stop.
// Notes: The count saturates rather than wrapping, so a long run never reads short.
`timescale 1ns/1ps
module mrm_dqs_osc (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control and count
  mrm_osc_if.osc osc
);

  mrm_pkg::mrm_osc_state_t st;
  mrm_pkg::mrm_osc_state_t next_st;
  logic [11:0] limit;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state. A start restarts the count even if a stop arrives alongside.
  always_comb begin
    limit = {osc.run_time, 4'h0} >> (4'h4 - mrm_pkg::OSC_STEP_LOG2);
    next_st = st;
    if (osc.start) begin
      next_st.running = 1'b1;
      next_st.timer = 12'h000;
      next_st.count = 16'h0000;
    end else if (st.running) begin
      next_st.timer = st.timer + 12'h001;
      if (st.count != 16'hFFFF) begin
        next_st.count = st.count + 16'h0001;
      end
      if (osc.stop || (osc.run_time != 8'h00 && next_st.timer == limit)) begin
        next_st.running = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign osc.count = st.count;
  assign osc.running = st.running;

  // The count only grows while running and holds once stopped.
  AST_OSC_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    (!st.running && !osc.start) |=> $stable(st.count))
    else $error("Oscillator count moved while stopped.");

endmodule // mrm_dqs_osc

// [mrm_access_decode.sv]
// Purpose: Classify a mode-register address and give its reserved-bit mask.
// Assumes: Addresses outside the known set are reserved or not to be used.
// Notes: Purely combinational.
`timescale 1ns/1ps
module mrm_access_decode (
  // Address in
  input wire logic [7:0] addr,
  // Classification out
  output mrm_pkg::mrm_access_t access,
  output logic [7:0] rfu_mask
);

  // Address map lookup.
  always_comb begin
    rfu_mask = mrm_pkg::RFU_NONE;
    case (addr)
      mrm_pkg::ADDR_CA_VREF, mrm_pkg::ADDR_DQ_VREF: begin
        access = mrm_pkg::MRM_ACC_RW;
        rfu_mask = mrm_pkg::RFU_VREF;
      end
      mrm_pkg::ADDR_TRR: begin
        access = mrm_pkg::MRM_ACC_RW;
      end
      mrm_pkg::ADDR_CNT_LOW, mrm_pkg::ADDR_CNT_HIGH, mrm_pkg::ADDR_REPAIR: begin
        access = mrm_pkg::MRM_ACC_RO;
      end
      mrm_pkg::ADDR_CAL_RESET, mrm_pkg::ADDR_TERMINATION, mrm_pkg::ADDR_REG_CTRL,
      mrm_pkg::ADDR_LB_INV, mrm_pkg::ADDR_BANK_MASK, mrm_pkg::ADDR_SEG_MASK,
      mrm_pkg::ADDR_UB_INV, mrm_pkg::ADDR_VENDOR, mrm_pkg::ADDR_TERM2,
      mrm_pkg::ADDR_OSC_RUN, mrm_pkg::ADDR_PAT_A, mrm_pkg::ADDR_PAT_B: begin
        access = mrm_pkg::MRM_ACC_WO;
      end
      default: begin
        access = mrm_pkg::MRM_ACC_NONE;
      end
    endcase
  end

endmodule // mrm_access_decode

// [mrm_mode_regs.sv]
// Purpose: Upper mode-register bank, 0Ah to 3Fh, written and read by command.
// Assumes: Write and read strobes come from the command decoder on clk.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
module mrm_mode_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register command
  input wire logic mrw_valid,
  input wire logic mrr_valid,
  input wire logic [7:0] mr_addr,
  input wire logic [7:0] mr_wdata,
  // Read return
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Oscillator commands and repair status
  input wire logic osc_start,
  input wire logic osc_stop,
  input wire logic [7:0] repair_resources,
  // Register contents to the device
  output logic [7:0] io_calibration_reset,
  output logic [7:0] termination_setting,
  output logic [7:0] command_bus_reference_level,
  output logic [7:0] register_control,
  output logic [7:0] data_bus_reference_level,
  output logic [7:0] lower_byte_cal_invert,
  output logic [7:0] self_refresh_bank_mask,
  output logic [7:0] self_refresh_segment_mask,
  output logic [7:0] upper_byte_cal_invert,
  output logic [7:0] vendor_use,
  output logic [7:0] termination_feature_two,
  output logic [7:0] strobe_osc_run_time,
  output logic [7:0] row_hammer_control,
  output logic [7:0] cal_pattern_a,
  output logic [7:0] cal_pattern_b
);

  mrm_pkg::mrm_state_t st;
  mrm_pkg::mrm_state_t next_st;
  mrm_pkg::mrm_access_t access;
  logic [7:0] rfu_mask;
  logic [7:0] read_value;
  logic [15:0] osc_count;
  logic wr_ok;

  mrm_osc_if osc_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // Address classification.
  mrm_access_decode u_decode (
    .addr(mr_addr),
    .access(access),
    .rfu_mask(rfu_mask)
  );

  // Strobe oscillator counter.
  mrm_dqs_osc u_osc (
    .clk(clk),
    .arst_n(arst_n),
    .osc(osc_bus)
  );

  // Oscillator control comes straight from the command strobes so a start
  // is never delayed behind a register write in the same cycle.
  assign osc_bus.start = osc_start;
  assign osc_bus.stop = osc_stop;
  assign osc_bus.run_time = st.osc_run;
  assign osc_count = osc_bus.count;

  ////////////////////////////////////////////////////////////////////////////////
  // Read value before reserved-bit clearing.
  always_comb begin
    read_value = 8'h00;
    case (mr_addr)
      mrm_pkg::ADDR_CA_VREF: begin
        read_value = st.ca_vref;
      end
      mrm_pkg::ADDR_DQ_VREF: begin
        read_value = st.dq_vref;
      end
      mrm_pkg::ADDR_TRR: begin
        read_value = st.trr;
      end
      mrm_pkg::ADDR_CNT_LOW: begin
        read_value = osc_count[7:0];
      end
      mrm_pkg::ADDR_CNT_HIGH: begin
        read_value = osc_count[15:8];
      end
      mrm_pkg::ADDR_REPAIR: begin
        read_value = repair_resources;
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  end

  // Writes land only on writable classes; read-only and reserved are dropped.
  // read-only writes ignored
  assign wr_ok = mrw_valid &&
    (access == mrm_pkg::MRM_ACC_WO || access == mrm_pkg::MRM_ACC_RW);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the bank.
  always_comb begin
    next_st = st;
    next_st.rd_valid = mrr_valid;
    if (mrr_valid) begin
      if (access == mrm_pkg::MRM_ACC_RO || access == mrm_pkg::MRM_ACC_RW) begin
        next_st.rd_data = read_value & ~rfu_mask;
      end else begin
        next_st.rd_data = 8'h00;
      end
    end
    if (wr_ok) begin
      case (mr_addr)
        mrm_pkg::ADDR_CAL_RESET: begin
          next_st.cal_reset = mr_wdata;
        end
        mrm_pkg::ADDR_TERMINATION: begin
          next_st.termination = mr_wdata;
        end
        mrm_pkg::ADDR_CA_VREF: begin
          next_st.ca_vref = mr_wdata;
        end
        mrm_pkg::ADDR_REG_CTRL: begin
          next_st.reg_ctrl = mr_wdata;
        end
        mrm_pkg::ADDR_DQ_VREF: begin
          next_st.dq_vref = mr_wdata;
        end
        mrm_pkg::ADDR_LB_INV: begin
          next_st.lb_inv = mr_wdata;
        end
        mrm_pkg::ADDR_BANK_MASK: begin
          next_st.bank_mask = mr_wdata;
        end
        mrm_pkg::ADDR_SEG_MASK: begin
          next_st.seg_mask = mr_wdata;
        end
        mrm_pkg::ADDR_UB_INV: begin
          next_st.ub_inv = mr_wdata;
        end
        mrm_pkg::ADDR_VENDOR: begin
          next_st.vendor = mr_wdata;
        end
        mrm_pkg::ADDR_TERM2: begin
          next_st.term2 = mr_wdata;
        end
        mrm_pkg::ADDR_OSC_RUN: begin
          next_st.osc_run = mr_wdata;
        end
        mrm_pkg::ADDR_TRR: begin
          next_st.trr = mr_wdata;
        end
        mrm_pkg::ADDR_PAT_A: begin
          next_st.pat_a = mr_wdata;
        end
        mrm_pkg::ADDR_PAT_B: begin
          next_st.pat_b = mr_wdata;
        end
        default: begin
          next_st.trr = st.trr;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register. Reference levels reset to their power-up range and value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.ca_vref <= mrm_pkg::RST_VREF;
      st.dq_vref <= mrm_pkg::RST_VREF;
      st.rd_data <= mrm_pkg::RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are taken straight from the state flops.
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
  assign io_calibration_reset = st.cal_reset;
  assign termination_setting = st.termination;
  assign command_bus_reference_level = st.ca_vref;
  assign register_control = st.reg_ctrl;
  assign data_bus_reference_level = st.dq_vref;
  assign lower_byte_cal_invert = st.lb_inv;
  assign self_refresh_bank_mask = st.bank_mask;
  assign self_refresh_segment_mask = st.seg_mask;
  assign upper_byte_cal_invert = st.ub_inv;
  assign vendor_use = st.vendor;
  assign termination_feature_two = st.term2;
  assign strobe_osc_run_time = st.osc_run;
  assign row_hammer_control = st.trr;
  assign cal_pattern_a = st.pat_a;
  assign cal_pattern_b = st.pat_b;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the bank.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Reserved top bit of both reference-level registers always reads zero.
  AST_RFU_READ_ZERO: assert property (
    (mrr_valid && (mr_addr == mrm_pkg::ADDR_CA_VREF || mr_addr == mrm_pkg::ADDR_DQ_VREF))
    |=> (rd_valid && rd_data[7] == 1'b0))
    else $error("Reserved bit read back as one.");

  // Write-only and reserved addresses read back as zero one cycle later.
  AST_WO_READ: assert property (
    (mrr_valid && (mr_addr == mrm_pkg::ADDR_LB_INV || mr_addr == mrm_pkg::ADDR_PAT_A
    || mr_addr == mrm_pkg::ADDR_VENDOR || mr_addr == 8'h3F))
    |=> (rd_valid && rd_data == 8'h00))
    else $error("Write-only read returned nonzero.");

  // A write to a read-only register leaves the read-write registers and the run-time setting alone.
  AST_RO_WRITE: assert property (
    (mrw_valid && (mr_addr == mrm_pkg::ADDR_CNT_LOW || mr_addr == mrm_pkg::ADDR_REPAIR))
    |=> $stable({command_bus_reference_level, data_bus_reference_level, row_hammer_control,
    strobe_osc_run_time}))
    else $error("Read-only write changed a register.");

  // Lower-byte invert takes the written value.
  AST_LB_INV: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_LB_INV)
    |=> (lower_byte_cal_invert == $past(mr_wdata)))
    else $error("Lower-byte invert not written.");

  // Upper-byte invert takes the written value.
  AST_UB_INV: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_UB_INV)
    |=> (upper_byte_cal_invert == $past(mr_wdata)))
    else $error("Upper-byte invert not written.");

  // Count low byte is returned one cycle after the read.
  AST_CNT_LOW: assert property (
    (mrr_valid && mr_addr == mrm_pkg::ADDR_CNT_LOW)
    |=> (rd_data == $past(osc_count[7:0])))
    else $error("Count low byte wrong.");

  // Count high byte is returned one cycle after the read.
  AST_CNT_HIGH: assert property (
    (mrr_valid && mr_addr == mrm_pkg::ADDR_CNT_HIGH)
    |=> (rd_data == $past(osc_count[15:8])))
    else $error("Count high byte wrong.");

  // Run-time setting is stored and then holds until rewritten.
  AST_OSC_RUN: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_OSC_RUN)
    |=> (strobe_osc_run_time == $past(mr_wdata)) ##1
    (($past(mrw_valid) && $past(mr_addr) == mrm_pkg::ADDR_OSC_RUN)
    || $stable(strobe_osc_run_time)))
    else $error("Run-time setting not written.");

  // Pattern A takes its written value and leaves pattern B alone.
  AST_PATTERNS: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_PAT_A)
    |=> (cal_pattern_a == $past(mr_wdata) && $stable(cal_pattern_b)))
    else $error("Pattern A write wrong.");

  // Bank mask takes the written value.
  AST_BANK_MASK: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_BANK_MASK)
    |=> (self_refresh_bank_mask == $past(mr_wdata)))
    else $error("Bank mask not written.");

  // Pattern B takes its written value and leaves pattern A alone.
  AST_PATTERN_B: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_PAT_B)
    |=> (cal_pattern_b == $past(mr_wdata) && $stable(cal_pattern_a)))
    else $error("Pattern B write wrong.");

  // Every read is answered by a valid pulse, whatever the address.
  AST_READ_ANSWERED: assert property (
    mrr_valid |=> rd_valid)
    else $error("Read not answered.");

  // No valid pulse appears without a read one cycle before.
  AST_READ_QUIET: assert property (
    !mrr_valid |=> !rd_valid)
    else $error("Read data valid without a read.");

  // Repair status has no reserved bits, so it is returned whole.
  AST_REPAIR_READ: assert property (
    (mrr_valid && mr_addr == mrm_pkg::ADDR_REPAIR)
    |=> (rd_data == $past(repair_resources)))
    else $error("Repair status read wrong.");

  // A write aimed at the count high byte leaves both byte inverts, the bank mask and both patterns alone.
  AST_RO_WRITE_WO: assert property (
    (mrw_valid && mr_addr == mrm_pkg::ADDR_CNT_HIGH)
    |=> $stable({lower_byte_cal_invert, upper_byte_cal_invert, self_refresh_bank_mask,
    cal_pattern_a, cal_pattern_b}))
    else $error("Read-only write changed a write-only register.");

  // A start clears the count and sets the oscillator running.
  AST_OSC_START: assert property (
    osc_start |=> (osc_count == 16'h0000 && osc_bus.running))
    else $error("Oscillator start did not clear the count.");

  // While running, the count steps by one each cycle until it saturates.
  AST_OSC_STEP: assert property (
    (osc_bus.running && !osc_start && osc_count != 16'hFFFF)
    |=> (osc_count == $past(osc_count) + 16'h0001))
    else $error("Oscillator count did not step.");

  // A run ended by its time setting stops at the setting times the step.
  AST_OSC_LIMIT: assert property (
    ($fell(osc_bus.running) && !$past(osc_stop) && strobe_osc_run_time != 8'h00)
    |-> (osc_count == (16'(strobe_osc_run_time) << mrm_pkg::OSC_STEP_LOG2)))
    else $error("Oscillator stopped at the wrong count.");

endmodule // mrm_mode_regs

// [mrm_ctrl_model.sv]
// Purpose: Behavioural memory controller issuing mode-register writes and reads.
// Assumes: One command per strobe pulse, driven 1 ns after a rising edge.
// Notes: The gap variable adds idle cycles before each command for slow issue.
`timescale 1ns/1ps
module mrm_ctrl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register command
  output logic mrw_valid,
  output logic mrr_valid,
  output logic [7:0] mr_addr,
  output logic [7:0] mr_wdata,
  // Read return
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  int gap = 0;

  // Idle bus at time zero.
  initial begin
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    mr_addr = 8'h00;
    mr_wdata = 8'h00;
  end

  function automatic logic usable(input logic [7:0] a);
    return !((a >= 8'h1A && a <= 8'h1F) || (a >= 8'h21 && a <= 8'h27) || a >= 8'h29);
  endfunction

  // Released lines show the inverse so a stale value is never mistaken for live.
  task automatic issue(input logic [7:0] a, input logic [7:0] d, input logic wr);
    repeat (gap + 1) @(posedge clk);
    #1;
    mr_addr = a;
    mr_wdata = d;
    mrw_valid = wr;
    mrr_valid = !wr;
    @(posedge clk);
    #1;
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    mr_addr = ~a;
    mr_wdata = ~d;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] mask;
    mask = (a == 8'h0C || a == 8'h0E) ? 8'h80 : 8'h00;
    if (usable(a)) begin
      issue(a, d & ~mask, 1'b1);
    end
  endtask

  // Read waits a bounded number of edges for the answer.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    issue(a, 8'h00, 1'b0);
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
      end
    end
  endtask
endmodule // mrm_ctrl_model

// [tb.sv]
// Purpose: Self-checking bench of the upper mode-register bank.
// Assumes: Controller model issues all register commands.
// Notes: Timed oscillator runs use run-time settings 1 to 3 to keep the run short; a zero-setting run is stopped by hand.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk, arst_n, osc_start, osc_stop, mrw_valid, mrr_valid, rd_valid, ok;
  logic [7:0] mr_addr, mr_wdata, rd_data, repair, d, d2, lo, hi;
  logic [7:0] o [15];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [7:0] WA [15] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
    8'h11, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h20, 8'h28};

  mrm_mode_regs i_dut (.clk(clk), .arst_n(arst_n), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .osc_start(osc_start), .osc_stop(osc_stop),
    .repair_resources(repair), .io_calibration_reset(o[0]), .termination_setting(o[1]),
    .command_bus_reference_level(o[2]), .register_control(o[3]),
    .data_bus_reference_level(o[4]), .lower_byte_cal_invert(o[5]),
    .self_refresh_bank_mask(o[6]), .self_refresh_segment_mask(o[7]),
    .upper_byte_cal_invert(o[8]), .vendor_use(o[9]), .termination_feature_two(o[10]),
    .strobe_osc_run_time(o[11]), .row_hammer_control(o[12]), .cal_pattern_a(o[13]),
    .cal_pattern_b(o[14]));

  mrm_ctrl_model i_ctrl (.clk(clk), .arst_n(arst_n), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data));

  ////////////////////////////////////////////////////////////////////////////////////
  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Both reference levels come up at 4Dh, the rest at zero.
  task automatic chk_reset();
    for (int i = 0; i < 15; i++) begin
      `CHK(o[i], (i == 2 || i == 4) ? 8'h4D : 8'h00)
    end
  endtask

  task automatic pulse(input bit stop);
    @(posedge clk);
    #1;
    if (stop) begin
      osc_stop = 1'b1;
    end else begin
      osc_start = 1'b1;
    end
    @(posedge clk);
    #1;
    osc_stop = 1'b0;
    osc_start = 1'b0;
  endtask

  function automatic logic [7:0] pat(input int i);
    logic [7:0] v;
    v = 8'hA3 ^ 8'(i * 8'h1D);
    return (i == 2 || i == 4) ? (v & 8'h7F) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    osc_start = 1'b0;
    osc_stop = 1'b0;
    repair = 8'hA5;
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk_reset();
    for (int i = 0; i < 15; i++) begin
      i_ctrl.write_reg(WA[i], pat(i));
    end
    for (int i = 0; i < 15; i++) begin
      `CHK(o[i], pat(i))
    end
    i_ctrl.read_reg(8'h0C, d, ok);
    `CHK(d, pat(2))
    i_ctrl.read_reg(8'h0E, d, ok);
    `CHK(d[7], 1'b0)
    i_ctrl.read_reg(8'h18, d, ok);
    `CHK(d, pat(12))
    i_ctrl.gap = 3;
    i_ctrl.read_reg(8'h0F, d, ok);
    `CHK(ok, 1'b1)
    i_ctrl.gap = 0;
    // Reserved register reads still answer, with zero.
    i_ctrl.read_reg(8'h3F, d, ok);
    `CHK(d, 8'h00)
    i_ctrl.write_reg(8'h19, 8'h5A);
    i_ctrl.write_reg(8'h12, 8'hFF);
    i_ctrl.write_reg(8'h13, 8'hFF);
    i_ctrl.read_reg(8'h19, d, ok);
    `CHK(d, 8'hA5)
    i_ctrl.read_reg(8'h12, d, ok);
    `CHK(d, 8'h00)
    for (int i = 0; i < 15; i++) begin
      `CHK(o[i], pat(i))
    end
    for (int n = 1; n <= 3; n++) begin
      i_ctrl.write_reg(8'h17, 8'(n));
      `CHK(o[11], 8'(n))
      pulse(1'b0);
      repeat (n * 16 + 10) @(posedge clk);
      i_ctrl.read_reg(8'h13, hi, ok);
      i_ctrl.read_reg(8'h12, lo, ok);
      `CHK({hi, lo}, 16'(n * 16))
    end
    // zero setting runs until stopped, then holds.
    i_ctrl.write_reg(8'h17, 8'h00);
    pulse(1'b0);
    repeat (70) @(posedge clk);
    pulse(1'b1);
    i_ctrl.read_reg(8'h12, d, ok);
    repeat (10) @(posedge clk);
    i_ctrl.read_reg(8'h12, d2, ok);
    `CHK(d2, d)
    `CHK(d > 8'h30, 1'b1)
    // Second reset in mid-run restores reset values.
    pulse(1'b0);
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk_reset();
    i_ctrl.read_reg(8'h13, d, ok);
    `CHK(d, 8'h00)
    wrap_up();
  end
endmodule // tb
